// File: tmoc_params.svh
/*
 * Constants for the timer channel mode and output control block:
 * register offsets, writable-bit masks, field positions and reset values.
 * Assumes it is included by bare name wherever the numbers are needed.
 */
`ifndef TMOC_PARAMS_SVH
`define TMOC_PARAMS_SVH

// Address pages: paddr[11:8] picks the channel page or the global page.
`define TMOC_PAGE_CH 4'h0
`define TMOC_PAGE_GLB 4'h1

// Byte offsets inside one channel window; paddr[7:6] is the channel.
`define TMOC_OFF_CNT 6'h00
`define TMOC_OFF_GA 6'h04
`define TMOC_OFF_GB 6'h08
`define TMOC_OFF_GC 6'h0c
`define TMOC_OFF_GD 6'h10
`define TMOC_OFF_MODE 6'h14
`define TMOC_OFF_OUT 6'h18
`define TMOC_OFF_CLR 6'h1c

// Byte offsets inside the global page.
`define TMOC_OFF_RUN 6'h00
`define TMOC_OFF_STS 6'h04
`define TMOC_OFF_MSK 6'h08

// Writable bits; every other bit reads as zero.
`define TMOC_MODE_WMASK 16'h0077
`define TMOC_OUT_WMASK 16'h0007
`define TMOC_CLR_WMASK 16'h0007

// Field positions in the channel mode control register.
`define TMOC_MODE_BUF_A 4
`define TMOC_MODE_BUF_B 5
`define TMOC_MODE_BUF_WT 6

// Counter clear select codes.
`define TMOC_CLR_BY_A 3'b001
`define TMOC_CLR_BY_B 3'b010

// Reset value and counter maximum.
`define TMOC_RST16 16'h0000
`define TMOC_CNT_MAX 16'hffff

`endif

// File: tmoc_pkg.sv
/*
 * Types shared by the timer channel mode and output control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tmoc_pkg;

    // Operating mode codes; every other code is reserved to software.
    typedef enum logic [2:0] {
        TMOC_OPM_NORMAL = 3'b000,
        TMOC_OPM_PWM = 3'b010
    } tmoc_opmode_t;

    // Bus slave states.
    typedef enum logic [1:0] {
        TMOC_ST_IDLE = 2'b00,
        TMOC_ST_ANS = 2'b01
    } tmoc_apb_state_t;

    // Register kinds; the first five double as the channel write index.
    typedef enum logic [3:0] {
        TMOC_K_CNT = 4'b0000,
        TMOC_K_GA = 4'b0001,
        TMOC_K_GB = 4'b0010,
        TMOC_K_GC = 4'b0011,
        TMOC_K_GD = 4'b0100,
        TMOC_K_MODE = 4'b0101,
        TMOC_K_OUT = 4'b0110,
        TMOC_K_CLR = 4'b0111,
        TMOC_K_RUN = 4'b1000,
        TMOC_K_STS = 4'b1001,
        TMOC_K_MSK = 4'b1010,
        TMOC_K_NONE = 4'b1111
    } tmoc_kind_t;

endpackage

// File: tmoc_counter.sv
/*
 * One channel's 16-bit counter and its four compare registers, with the
 * buffered reload of A from C and B from D.
 * Assumes configuration is only changed while the counter is halted.
 */
`timescale 1ns/1ps
`include "tmoc_params.svh"

module tmoc_counter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Configuration
    input wire logic run,
    input wire logic [2:0] clr_sel,
    input wire logic buf_a,
    input wire logic buf_b,
    input wire logic buf_wt,
    // Register write port
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [15:0] wr_data,
    // State and events
    output logic [15:0] cnt_q,
    output logic [3:0][15:0] cmp_q,
    output logic match_a,
    output logic clr_evt,
    output logic ovf
);
    import tmoc_pkg::*;

    logic match_b;
    logic upd_a;
    logic upd_b;

    // Matches count only while running, so a halted counter raises no events.
    assign match_a = run && (cnt_q == cmp_q[0]);
    assign match_b = run && (cnt_q == cmp_q[1]);
    assign clr_evt = (clr_sel == `TMOC_CLR_BY_A && match_a) || (clr_sel == `TMOC_CLR_BY_B && match_b);
    assign ovf = run && !clr_evt && (cnt_q == `TMOC_CNT_MAX);
    // The timing bit only matters once a pair is buffered.
    assign upd_a = buf_a && (buf_wt ? clr_evt : match_a);
    assign upd_b = buf_b && (buf_wt ? clr_evt : match_b);

    // Counter: software write first, then clear, else increment and wrap.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q <= `TMOC_RST16;
        end else if (wr_en && wr_idx == 3'd0) begin
            cnt_q <= wr_data;
        end else if (run) begin
            cnt_q <= clr_evt ? `TMOC_RST16 : cnt_q + 16'h0001;
        end
    end

    // Compare registers; a software write beats a buffer transfer.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmp_q <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_en && wr_idx == 3'(i + 1)) begin
                    cmp_q[i] <= wr_data;
                end
            end
            if (upd_a && !(wr_en && wr_idx == 3'd1)) begin
                cmp_q[0] <= cmp_q[2];
            end
            if (upd_b && !(wr_en && wr_idx == 3'd2)) begin
                cmp_q[1] <= cmp_q[3];
            end
        end
    end

    // A quiet cycle: no write lands on the channel.
    sequence s_no_wr;
        !wr_en;
    endsequence

    property p_buf_a_match;
        @(posedge core_clk) disable iff (sys_rst)
        (buf_a && !buf_wt && match_a) ##0 s_no_wr |=> (cmp_q[0] == $past(cmp_q[2]));
    endproperty
    a_buf_a_match: assert property (p_buf_a_match) else $error("A not reloaded from C on match");

    property p_buf_b_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (buf_b && buf_wt && clr_evt) ##0 s_no_wr |=> (cmp_q[1] == $past(cmp_q[3]));
    endproperty
    a_buf_b_clear: assert property (p_buf_b_clear) else $error("B not reloaded from D on clear");

    property p_no_buf;
        @(posedge core_clk) disable iff (sys_rst)
        (!buf_a && !buf_b) ##0 s_no_wr |=> $stable(cmp_q[1:0]);
    endproperty
    a_no_buf: assert property (p_no_buf) else $error("compare changed without buffering");

    property p_wrap;
        @(posedge core_clk) disable iff (sys_rst)
        (ovf || clr_evt) ##0 s_no_wr |=> (cnt_q == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter not zero after wrap or clear");
endmodule

// File: tmoc_pin.sv
/*
 * Timer output pin logic for one channel, driven by compare register A.
 * Assumes match and clear events come from the channel counter.
 */
`timescale 1ns/1ps

module tmoc_pin (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Configuration
    input wire logic run,
    input wire logic pwm,
    input wire logic [2:0] sel,
    // Events
    input wire logic match_a,
    input wire logic clr_evt,
    // Pin
    output logic pin_q
);
    import tmoc_pkg::*;

    logic active;

    // Pulse-width mode only honours set-on-match from low and clear from high.
    assign active = !pwm || sel == 3'b010 || sel == 3'b101;

    // Halted or constant codes hold the initial level; running codes act on match.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
        end else if (!run || sel[1:0] == 2'b00) begin
            pin_q <= sel[2];
        end else if (match_a && active) begin
            case (sel[1:0])
                2'b01: pin_q <= 1'b0;
                2'b10: pin_q <= 1'b1;
                default: pin_q <= ~pin_q;
            endcase
        end else if (pwm && clr_evt) begin
            pin_q <= sel[2];
        end
    end

    // A running match that pin select would act on in normal mode.
    sequence s_live_match;
        run && match_a && sel[1:0] != 2'b00;
    endsequence

    property p_level_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (!run || sel[1:0] == 2'b00) |=> (pin_q == $past(sel[2]));
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("pin not at initial or constant level");

    property p_toggle;
        @(posedge core_clk) disable iff (sys_rst)
        s_live_match ##0 (!pwm && sel[1:0] == 2'b11) |=> (pin_q != $past(pin_q));
    endproperty
    a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");

    property p_pwm_ignore;
        @(posedge core_clk) disable iff (sys_rst)
        s_live_match ##0 (pwm && !clr_evt && !active) |=> $stable(pin_q);
    endproperty
    a_pwm_ignore: assert property (p_pwm_ignore) else $error("invalid code acted in pulse-width mode");
endmodule

// File: tmoc_top.sv
/*
 * Four-channel timer mode and output control with an APB register slave,
 * sticky event status, interrupt mask and one timer output pin per channel.
 * Assumes a single core clock, a synchronous active-high reset and an APB
 * master that holds each request until it sees pready high.
 */
// How it works
// - Every channel owns a 16-bit read/write mode control register.
// - Reserved bits of both registers read zero and ignore writes.
// - Mode bit 4 pairs compare A with C as a buffer.
// - Mode bit 5 pairs compare B with D as a buffer.
// - Mode bit 6 reloads on own match when zero, on clear when one.
// - The write timing bit is ignored when no pair is buffered.
// - Operating mode 000 is normal, 010 is pulse width; others not written.
// - Output select 000 holds the pin low, 100 holds it high.
// - Codes 1 to 3 start low, then low, high or toggle on match.
// - Codes 5 to 7 start high, then low, high or toggle on match.
// - Pulse-width mode ignores output codes 1, 3, 6 and 7.
// - Counter clears on compare A match (001) or compare B match (010).
// - The 16-bit counter flags overflow when it wraps from maximum to zero.
`timescale 1ns/1ps
`include "tmoc_params.svh"

module tmoc_top #(
    parameter int NCH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer output pins and interrupt
    output logic [NCH-1:0] timer_output_pin,
    output logic irq
);
    import tmoc_pkg::*;

    tmoc_apb_state_t st_q;
    tmoc_kind_t kind;
    logic [1:0] ch;
    logic wr_fire;
    logic [31:0] rd_d;
    logic [15:0] mode_q [NCH];
    logic [15:0] out_q [NCH];
    logic [15:0] clr_q [NCH];
    logic [NCH-1:0] run_q;
    logic [2*NCH-1:0] sts_q;
    logic [2*NCH-1:0] msk_q;
    logic [2*NCH-1:0] sts_set;
    logic [2*NCH-1:0] sts_clr;
    logic [15:0] cnt_w [NCH];
    logic [3:0][15:0] cmp_w [NCH];
    logic [NCH-1:0] match_w;
    logic [NCH-1:0] clrev_w;
    logic [NCH-1:0] ovf_w;
    logic [NCH-1:0] pwm_w;

    // Address decode into a register kind; unmapped or unaligned is none.
    function automatic tmoc_kind_t tmoc_decode(input logic [11:0] a);
        tmoc_kind_t k;
        k = TMOC_K_NONE;
        if (a[1:0] != 2'b00) begin
            k = TMOC_K_NONE;
        end else if (a[11:8] == `TMOC_PAGE_CH && int'(a[7:6]) < NCH) begin
            if (a[5:0] == `TMOC_OFF_CNT) k = TMOC_K_CNT;
            else if (a[5:0] == `TMOC_OFF_GA) k = TMOC_K_GA;
            else if (a[5:0] == `TMOC_OFF_GB) k = TMOC_K_GB;
            else if (a[5:0] == `TMOC_OFF_GC) k = TMOC_K_GC;
            else if (a[5:0] == `TMOC_OFF_GD) k = TMOC_K_GD;
            else if (a[5:0] == `TMOC_OFF_MODE) k = TMOC_K_MODE;
            else if (a[5:0] == `TMOC_OFF_OUT) k = TMOC_K_OUT;
            else if (a[5:0] == `TMOC_OFF_CLR) k = TMOC_K_CLR;
        end else if (a[11:8] == `TMOC_PAGE_GLB && a[7:6] == 2'b00) begin
            if (a[5:0] == `TMOC_OFF_RUN) k = TMOC_K_RUN;
            else if (a[5:0] == `TMOC_OFF_STS) k = TMOC_K_STS;
            else if (a[5:0] == `TMOC_OFF_MSK) k = TMOC_K_MSK;
        end
        return k;
    endfunction

    assign kind = tmoc_decode(paddr);
    assign ch = paddr[7:6];
    // Writes land at the edge where the master samples pready high.
    assign wr_fire = (st_q == TMOC_ST_ANS) && psel && penable && pwrite && (kind != TMOC_K_NONE);

    // Read mux; reserved bits come back as zero through the stored masks.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (kind)
            TMOC_K_CNT: rd_d = {16'h0000, cnt_w[ch]};
            TMOC_K_GA: rd_d = {16'h0000, cmp_w[ch][0]};
            TMOC_K_GB: rd_d = {16'h0000, cmp_w[ch][1]};
            TMOC_K_GC: rd_d = {16'h0000, cmp_w[ch][2]};
            TMOC_K_GD: rd_d = {16'h0000, cmp_w[ch][3]};
            TMOC_K_MODE: rd_d = {16'h0000, mode_q[ch]};
            TMOC_K_OUT: rd_d = {16'h0000, out_q[ch]};
            TMOC_K_CLR: rd_d = {16'h0000, clr_q[ch]};
            TMOC_K_RUN: rd_d = 32'(run_q);
            TMOC_K_STS: rd_d = 32'(sts_q);
            TMOC_K_MSK: rd_d = 32'(msk_q);
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Bus slave: one wait state, then a single-cycle pready pulse.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= TMOC_ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            case (st_q)
                TMOC_ST_IDLE: begin
                    if (psel && penable) begin
                        st_q <= TMOC_ST_ANS;
                        pready <= 1'b1;
                        pslverr <= (kind == TMOC_K_NONE);
                        prdata <= pwrite ? 32'h0000_0000 : rd_d;
                    end
                end
                default: begin
                    st_q <= TMOC_ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // Per-channel configuration; only documented bits are stored.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                mode_q[c] <= `TMOC_RST16;
                out_q[c] <= `TMOC_RST16;
                clr_q[c] <= `TMOC_RST16;
            end
        end else if (wr_fire) begin
            for (int c = 0; c < NCH; c++) begin
                if (int'(ch) == c && kind == TMOC_K_MODE) begin
                    mode_q[c] <= pwdata[15:0] & `TMOC_MODE_WMASK;
                end
                if (int'(ch) == c && kind == TMOC_K_OUT) begin
                    out_q[c] <= pwdata[15:0] & `TMOC_OUT_WMASK;
                end
                if (int'(ch) == c && kind == TMOC_K_CLR) begin
                    clr_q[c] <= pwdata[15:0] & `TMOC_CLR_WMASK;
                end
            end
        end
    end

    // Run bits start every counter independently.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            run_q <= '0;
        end else if (wr_fire && kind == TMOC_K_RUN) begin
            run_q <= pwdata[NCH-1:0];
        end
    end

    // Status bits: low half is compare A match, high half is overflow.
    assign sts_set = {ovf_w, match_w};
    assign sts_clr = (wr_fire && kind == TMOC_K_STS) ? pwdata[2*NCH-1:0] : '0;

    // Sticky status, write one to clear; a new event beats the clear.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sts_q <= '0;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end

    // Interrupt mask, same layout as status.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            msk_q <= '0;
        end else if (wr_fire && kind == TMOC_K_MSK) begin
            msk_q <= pwdata[2*NCH-1:0];
        end
    end

    // Level interrupt, registered so the pin never glitches.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sts_q & msk_q);
        end
    end

    // One counter and one pin driver per channel.
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // Only code 010 selects pulse width; other codes behave as normal.
        assign pwm_w[c] = (mode_q[c][2:0] == TMOC_OPM_PWM);

        tmoc_counter u_cnt (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .run(run_q[c]),
            .clr_sel(clr_q[c][2:0]),
            .buf_a(mode_q[c][`TMOC_MODE_BUF_A]),
            .buf_b(mode_q[c][`TMOC_MODE_BUF_B]),
            .buf_wt(mode_q[c][`TMOC_MODE_BUF_WT]),
            .wr_en(wr_fire && int'(ch) == c && kind <= TMOC_K_GD),
            .wr_idx(kind[2:0]),
            .wr_data(pwdata[15:0]),
            .cnt_q(cnt_w[c]),
            .cmp_q(cmp_w[c]),
            .match_a(match_w[c]),
            .clr_evt(clrev_w[c]),
            .ovf(ovf_w[c])
        );

        tmoc_pin u_pin (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .run(run_q[c]),
            .pwm(pwm_w[c]),
            .sel(out_q[c][2:0]),
            .match_a(match_w[c]),
            .clr_evt(clrev_w[c]),
            .pin_q(timer_output_pin[c])
        );
    end

    // A mode write arriving in the access phase.
    sequence s_mode_write;
        wr_fire && kind == TMOC_K_MODE;
    endsequence

    property p_mode_store;
        @(posedge core_clk) disable iff (sys_rst)
        s_mode_write |=> (mode_q[$past(ch)] == ($past(pwdata[15:0]) & 16'h0077));
    endproperty
    a_mode_store: assert property (p_mode_store) else $error("mode write not stored");

    property p_rsv_read;
        @(posedge core_clk) disable iff (sys_rst)
        (st_q == TMOC_ST_IDLE && psel && penable && !pwrite && kind == TMOC_K_MODE)
            |=> (pready && prdata[31:7] == 25'h0 && prdata[3] == 1'b0);
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("reserved mode bits read non-zero");

    property p_reset_clean;
        @(posedge core_clk)
        sys_rst |=> (mode_q[0] == 16'h0000 && out_q[0] == 16'h0000 && timer_output_pin == '0);
    endproperty
    a_reset_clean: assert property (p_reset_clean) else $error("state not zero after reset");

    property p_sticky;
        @(posedge core_clk) disable iff (sys_rst)
        sts_set[2*NCH-1] |=> sts_q[2*NCH-1] ##1 (irq || !msk_q[2*NCH-1] || !sts_q[2*NCH-1]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow lost or interrupt missing");
endmodule

// File: tmoc_pin_load.sv
/*
 * Load model for the timer output pins: counts level changes per channel.
 * Assumes the pins are registered levels in the core clock domain.
 */
`timescale 1ns/1ps

module tmoc_pin_load (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Pins and count clear
    input wire logic [3:0] pin,
    input wire logic zero,
    output logic [3:0][7:0] edges
);
    logic [3:0] last_q;

    // A plain load only notices level changes; it never drives the pin back.
    always_ff @(posedge core_clk) begin
        last_q <= pin;
        for (int i = 0; i < 4; i++) begin
            if (sys_rst || zero) begin
                edges[i] <= 8'h00;
            end else if (pin[i] !== last_q[i]) begin
                edges[i] <= edges[i] + 8'h01;
            end
        end
    end
endmodule

// File: testbench.sv
/*
 * Self-checking bench for the timer mode and output control block.
 * Assumes the APB map and one-wait-state slave described for the design.
 */
`timescale 1ns/1ps
`include "tmoc_params.svh"

module testbench;
    logic core_clk;
    logic sys_rst;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pins;
    logic irq;
    logic zero;
    logic [3:0][7:0] edges;
    logic [31:0] rdat;
    logic rerr;
    int num_errors;
    int checks;
    localparam logic [11:0] run_a = {`TMOC_PAGE_GLB, 2'b00, `TMOC_OFF_RUN};
    localparam logic [11:0] sts_a = {`TMOC_PAGE_GLB, 2'b00, `TMOC_OFF_STS};
    localparam logic [11:0] msk_a = {`TMOC_PAGE_GLB, 2'b00, `TMOC_OFF_MSK};

    tmoc_top #(.NCH(4)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_output_pin(pins), .irq(irq));
    tmoc_pin_load load (.core_clk(core_clk), .sys_rst(sys_rst), .pin(pins), .zero(zero), .edges(edges));

    // Free-running 100 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [11:0] ca(input logic [1:0] ch, input logic [5:0] off);
        return {`TMOC_PAGE_CH, ch, off};
    endfunction

    // Level after one compare A match; pulse-width mode ignores some codes.
    function automatic logic pin_after(input logic pwm, input logic [2:0] c);
        if (pwm && (c[1:0] == 2'b11 || c == 3'b001 || c == 3'b110)) begin
            return c[2];
        end
        case (c[1:0])
            2'b00: return c[2];
            2'b01: return 1'b0;
            2'b10: return 1'b1;
            default: return ~c[2];
        endcase
    endfunction

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    // Runs the channels in the run mask for n cycles and leaves them running.
    task automatic run_for(input logic [31:0] m, input int n);
        apb(1'b1, run_a, m);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs far fewer than 20000 cycles.
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        zero = 1'b0;
        num_errors = 0;
        checks = 0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(ca(2'd0, `TMOC_OFF_MODE), 32'h0, "mode reset");
        rd(ca(2'd0, `TMOC_OFF_OUT), 32'h0, "output reset");
        chk("pins reset", 32'h0, {28'h0, pins});
        apb(1'b1, ca(2'd1, `TMOC_OFF_MODE), 32'hfffffff2);
        rd(ca(2'd1, `TMOC_OFF_MODE), 32'h72, "mode reserved");
        apb(1'b1, ca(2'd1, `TMOC_OFF_OUT), 32'hffffffff);
        rd(ca(2'd1, `TMOC_OFF_OUT), 32'h7, "output reserved");
        apb(1'b0, 12'h204, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        // Every output code in both modes on channel 0, match at count 3.
        apb(1'b1, ca(2'd0, `TMOC_OFF_GA), 32'h3);
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                apb(1'b1, ca(2'd0, `TMOC_OFF_MODE), m ? 32'h2 : 32'h0);
                apb(1'b1, ca(2'd0, `TMOC_OFF_OUT), 32'(c));
                apb(1'b1, ca(2'd0, `TMOC_OFF_CNT), 32'h0);
                chk("pin halted", {31'h0, c[2]}, {31'h0, pins[0]});
                run_for(32'h1, 10);
                chk("pin matched", {31'h0, pin_after(m[0], c[2:0])}, {31'h0, pins[0]});
                apb(1'b1, run_a, 32'h0);
            end
        end
        // Sticky match status, mask and write-one clear.
        rd(sts_a, 32'h1, "match status");
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, msk_a, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, sts_a, 32'hff);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Channel 1: both pairs buffered, reload on own match.
        apb(1'b1, ca(2'd1, `TMOC_OFF_MODE), 32'h30);
        apb(1'b1, ca(2'd1, `TMOC_OFF_GA), 32'h5);
        apb(1'b1, ca(2'd1, `TMOC_OFF_GB), 32'h4);
        apb(1'b1, ca(2'd1, `TMOC_OFF_GC), 32'h9);
        apb(1'b1, ca(2'd1, `TMOC_OFF_GD), 32'h7);
        run_for(32'h2, 20);
        apb(1'b1, run_a, 32'h0);
        rd(ca(2'd1, `TMOC_OFF_GA), 32'h9, "A from C");
        rd(ca(2'd1, `TMOC_OFF_GB), 32'h7, "B from D");
        // Channel 2: both pairs reload on clear by B, then toggle on the new A.
        apb(1'b1, ca(2'd2, `TMOC_OFF_MODE), 32'h70);
        apb(1'b1, ca(2'd2, `TMOC_OFF_GA), 32'h9);
        apb(1'b1, ca(2'd2, `TMOC_OFF_GB), 32'h5);
        apb(1'b1, ca(2'd2, `TMOC_OFF_GC), 32'h2);
        apb(1'b1, ca(2'd2, `TMOC_OFF_GD), 32'h6);
        apb(1'b1, ca(2'd2, `TMOC_OFF_CLR), 32'(`TMOC_CLR_BY_B));
        apb(1'b1, ca(2'd2, `TMOC_OFF_OUT), 32'h3);
        zero <= 1'b1;
        @(posedge core_clk);
        zero <= 1'b0;
        run_for(32'h4, 40);
        chk("toggles", 32'h1, {31'h0, edges[2] >= 8'd5});
        apb(1'b1, run_a, 32'h0);
        rd(ca(2'd2, `TMOC_OFF_GA), 32'h2, "A at clear");
        rd(ca(2'd2, `TMOC_OFF_GB), 32'h6, "B at clear");
        // Channel 3: timing bit alone does nothing; counter wraps.
        apb(1'b1, ca(2'd3, `TMOC_OFF_MODE), 32'h40);
        apb(1'b1, ca(2'd3, `TMOC_OFF_GA), 32'h6);
        apb(1'b1, ca(2'd3, `TMOC_OFF_GC), 32'h1);
        apb(1'b1, ca(2'd3, `TMOC_OFF_CLR), 32'(`TMOC_CLR_BY_A));
        apb(1'b1, ca(2'd3, `TMOC_OFF_CNT), 32'hfff0);
        run_for(32'h8, 30);
        apb(1'b1, run_a, 32'h0);
        rd(ca(2'd3, `TMOC_OFF_GA), 32'h6, "A unbuffered");
        apb(1'b0, sts_a, 32'h0);
        chk("overflow", 32'h1, {31'h0, rdat[7]});
        tally_and_finish();
    end
endmodule
